// *** rtl/sdcr_regs.v ***
// top of the drive current register bank with ahb-lite slave
// assumes a single master and single-word transfers only
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sdcr_consts.vh"

module sdcr_regs #(
    parameter NCHAN = 4,
    parameter CODE_W = 5
) (
    input wire hclk,                       // bus clock, 250 MHz
    input wire hresetn,                    // async reset, active low
    input wire hsel,                       // slave select
    input wire [31:0] haddr,               // byte address
    input wire [1:0] htrans,               // transfer type
    input wire hwrite,                     // write when high
    input wire [2:0] hsize,                // transfer size
    input wire hready,                     // bus ready
    input wire [31:0] hwdata,              // write data
    output reg [31:0] hrdata,              // read data
    output reg hreadyout,                  // slave ready
    output reg hresp,                      // response, always okay
    input wire [NCHAN-1:0] cal_valid,      // calibration result strobes
    input wire [NCHAN*CODE_W-1:0] cal_code, // calibration results
    input wire [1:0] active_chan,          // channel now converting
    input wire activating,                 // sensor activation phase
    output reg drive_use_prog_q,           // use programmed drive
    output reg drive_max_q,                // drive maximum current
    output reg [CODE_W-1:0] drive_code_q,  // drive code for active channel
    output reg amp_corr_en_q,              // correction algorithm running
    output reg soft_reset_q                // device-wide soft reset level
);

    // ****************************************
    // bus capture
    // ****************************************
    reg wr_pend_q;
    reg rd_pend_q;
    reg [7:0] widx_q;
    reg [15:0] config_q;
    reg [CODE_W*NCHAN-1:0] prog_q;
    wire [CODE_W*NCHAN-1:0] cal_all;
    wire srst;
    reg srst_trig;
    wire take = hsel && hready && htrans[1];
    wire [7:0] ridx = haddr[9:2];

    function [31:0] read_mux;
        input [7:0] idx;
        input [15:0] cfg;
        input [CODE_W*NCHAN-1:0] prog;
        input [CODE_W*NCHAN-1:0] cal;
        integer k;
        begin
            read_mux = 32'h0000_0000;
            if (idx == `SDCR_IDX_CONFIG) begin
                read_mux = {16'h0000, cfg};
            end
            // soft reset register reads zero
            for (k = 0; k < NCHAN; k = k + 1) begin
                if (idx == `SDCR_IDX_CHAN0 + k[7:0]) begin
                    read_mux[`SDCR_CODE_HI:`SDCR_CODE_LO] = prog[k*CODE_W +: CODE_W];
                    read_mux[`SDCR_CAL_HI:`SDCR_CAL_LO] = cal[k*CODE_W +: CODE_W];
                end
            end
        end
    endfunction

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            widx_q <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= take && hwrite;
            rd_pend_q <= take && !hwrite;
            if (take) begin
                widx_q <= ridx;
            end
            // read data registered, so it stands in the data phase
            if (take && !hwrite) begin
                hrdata <= read_mux(ridx, config_q, prog_q, cal_all);
            end else begin
                hrdata <= 32'h0000_0000;
            end
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************
    // register writes
    // ****************************************
    integer i;

    always @* begin
        srst_trig = wr_pend_q && (widx_q == `SDCR_IDX_SOFT_RESET)
            && hwdata[`SDCR_RESET_BIT];
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_q <= `SDCR_CONFIG_RST;
            prog_q <= {(CODE_W*NCHAN){1'b0}};
        end else if (srst) begin
            config_q <= `SDCR_CONFIG_RST;
            prog_q <= {(CODE_W*NCHAN){1'b0}};
        end else if (wr_pend_q) begin
            if (widx_q == `SDCR_IDX_CONFIG) begin
                config_q <= hwdata[15:0];
            end
            for (i = 0; i < NCHAN; i = i + 1) begin
                if (widx_q == `SDCR_IDX_CHAN0 + i[7:0]) begin
                    prog_q[i*CODE_W +: CODE_W] <=
                        hwdata[`SDCR_CODE_HI:`SDCR_CODE_LO];
                end
            end
        end
    end

    // ****************************************
    // soft reset and calibrated codes
    // ****************************************
    // reset bit is never stored; the trigger is a pulse only
    sdcr_soft_reset u_srst (
        .hclk(hclk),
        .hresetn(hresetn),
        .trigger(srst_trig),
        .srst_q(srst)
    );

    genvar g;
    generate
        for (g = 0; g < NCHAN; g = g + 1) begin : g_cal
            sdcr_cal_store #(.CODE_W(CODE_W)) u_cal (
                .hclk(hclk),
                .hresetn(hresetn),
                .srst(srst),
                .amp_dis(config_q[`SDCR_CFG_AMPDIS_BIT]),
                .cal_valid(cal_valid[g]),
                .cal_code(cal_code[g*CODE_W +: CODE_W]),
                .code_q(cal_all[g*CODE_W +: CODE_W])
            );
        end
    endgenerate

    // ****************************************
    // drive control outputs
    // ****************************************
    wire ovr = config_q[`SDCR_CFG_OVERRIDE_BIT];
    wire lowp = config_q[`SDCR_CFG_ACTSEL_BIT];
    wire use_prog = activating ? lowp : ovr;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_use_prog_q <= 1'b0;
            drive_max_q <= 1'b0;
            drive_code_q <= `SDCR_CODE_RST;
            amp_corr_en_q <= 1'b0;
            soft_reset_q <= 1'b0;
        end else begin
            drive_use_prog_q <= use_prog;
            drive_max_q <= activating && !lowp;
            drive_code_q <= use_prog ? prog_q[active_chan*CODE_W +: CODE_W]
                : cal_all[active_chan*CODE_W +: CODE_W];
            amp_corr_en_q <= !config_q[`SDCR_CFG_AMPDIS_BIT];
            soft_reset_q <= srst;
        end
    end

endmodule

// *** rtl/sdcr_consts.vh ***
// constants for the sensor drive current register bank
// assumes word-indexed register map on a 32-bit ahb-lite bus
`ifndef SDCR_CONSTS_VH
`define SDCR_CONSTS_VH

// register indices; byte address is four times the index
`define SDCR_IDX_CONFIG 8'h1a
`define SDCR_IDX_SOFT_RESET 8'h1c
`define SDCR_IDX_CHAN0 8'h1e
`define SDCR_IDX_CHAN1 8'h1f
`define SDCR_IDX_CHAN2 8'h20
`define SDCR_IDX_CHAN3 8'h21

// field positions
`define SDCR_RESET_BIT 15
`define SDCR_CODE_HI 15
`define SDCR_CODE_LO 11
`define SDCR_CAL_HI 10
`define SDCR_CAL_LO 6
`define SDCR_CFG_OVERRIDE_BIT 12
`define SDCR_CFG_ACTSEL_BIT 11
`define SDCR_CFG_AMPDIS_BIT 10

// reset values
`define SDCR_CODE_RST 5'h0
`define SDCR_CONFIG_RST 16'h2801

// length of the internal soft reset pulse, in cycles
`define SDCR_SRST_CYCLES 4'h4

`endif

// *** rtl/sdcr_soft_reset.v ***
// soft reset pulse generator for the drive register bank
// assumes a one-cycle trigger pulse from the register decode
`timescale 1ns/1ps
`include "sdcr_consts.vh"

module sdcr_soft_reset (
    input wire hclk,       // bus clock
    input wire hresetn,    // async reset, active low
    input wire trigger,    // one-cycle request
    output reg srst_q      // synchronous reset level
);

    reg [3:0] cnt_q;

    // pulse stretched so every register sees it at least once
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 4'h0;
            srst_q <= 1'b0;
        end else if (trigger) begin
            cnt_q <= `SDCR_SRST_CYCLES;
            srst_q <= 1'b1;
        end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            srst_q <= (cnt_q != 4'h1);
        end else begin
            srst_q <= 1'b0;
        end
    end

endmodule

// *** rtl/sdcr_cal_store.v ***
// per-channel calibrated drive code store
// assumes the calibration engine strobes one channel at a time
`timescale 1ns/1ps
`include "sdcr_consts.vh"

module sdcr_cal_store #(
    parameter CODE_W = 5
) (
    input wire hclk,                 // bus clock
    input wire hresetn,              // async reset, active low
    input wire srst,                 // soft reset level
    input wire amp_dis,              // correction disable
    input wire cal_valid,            // calibration result strobe
    input wire [CODE_W-1:0] cal_code, // calibration result
    output reg [CODE_W-1:0] code_q   // stored calibrated code
);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            code_q <= `SDCR_CODE_RST;
        end else if (srst) begin
            code_q <= `SDCR_CODE_RST;
        end else if (cal_valid && !amp_dis) begin
            code_q <= cal_code;
        end
    end

endmodule

// *** sim/sdcr_chk.sv ***
// port assertions for the drive current register bank
// assumes it is bound to sdcr_regs
`timescale 1ns/1ps
`include "sdcr_consts.vh"

module sdcr_chk #(
    parameter NCHAN = 4,
    parameter CODE_W = 5
) (
    input wire hclk, // clock
    input wire hresetn, // reset
    input wire hsel, // select
    input wire [31:0] haddr, // address
    input wire [1:0] htrans, // type
    input wire hwrite, // write
    input wire hready, // ready
    input wire [31:0] hwdata, // wdata
    input wire [31:0] hrdata, // rdata
    input wire [NCHAN-1:0] cal_valid, // strobes
    input wire [NCHAN*CODE_W-1:0] cal_code, // results
    input wire [1:0] active_chan, // channel
    input wire activating, // activation
    input wire drive_use_prog_q, // prog
    input wire drive_max_q, // max
    input wire [CODE_W-1:0] drive_code_q, // code
    input wire soft_reset_q // soft reset
);
    // ****
    // shadow of the bus and of config bits 12:10
    // ****
    reg v_q, w_q, sr_q;
    reg [7:0] a_q;
    reg [2:0] cfg_q;

    // sr_q covers the soft reset, where shadow and config differ for a cycle
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {v_q, w_q, sr_q, a_q, cfg_q} <= 14'h0002;
        end else begin
            {v_q, w_q, a_q} <= {hsel && hready && htrans[1], hwrite, haddr[9:2]};
            if (v_q && w_q && a_q == `SDCR_IDX_CONFIG)
                cfg_q <= hwdata[12:10];
            if (v_q && w_q && a_q == `SDCR_IDX_SOFT_RESET && hwdata[15]) begin
                sr_q <= 1'b1;
                cfg_q <= 3'b010;
            end else if ($fell(soft_reset_q)) begin
                sr_q <= 1'b0;
            end
        end
    end

    // ****
    // properties
    // ****
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn || sr_q || soft_reset_q);

    AST_RST_RD: assert property (disable iff (!hresetn)
        v_q && !w_q && a_q == `SDCR_IDX_SOFT_RESET |-> hrdata == 32'h0000_0000)
        else $error("reset register read not zero");
    AST_RST_GO: assert property (disable iff (!hresetn)
        v_q && w_q && a_q == `SDCR_IDX_SOFT_RESET && hwdata[15] |-> ##[1:3] soft_reset_q)
        else $error("soft reset not started");
    AST_RST_LEN: assert property (disable iff (!hresetn)
        $rose(soft_reset_q) |-> soft_reset_q [*4] ##1 !soft_reset_q)
        else $error("soft reset length wrong");
    // full current activation outranks the override while activating
    AST_OVR: assert property (cfg_q[2] && !activating |=> drive_use_prog_q)
        else $error("override not applied");
    AST_LOWP: assert property (
        activating && cfg_q[1] |=> drive_use_prog_q && !drive_max_q)
        else $error("low power activation wrong");
    AST_FULL: assert property (
        activating && cfg_q[2:1] == 2'b00 |=> drive_max_q && !drive_use_prog_q)
        else $error("full current activation wrong");
    AST_CAL: assert property (
        cal_valid[active_chan] && cfg_q == 3'b010 && !activating
        |-> ##2 drive_code_q == $past(cal_code[active_chan*CODE_W +: CODE_W], 2))
        else $error("calibrated code not taken");
    AST_FRZ: assert property (
        cfg_q[0] && !cfg_q[2] && !activating && $stable({cfg_q, activating, active_chan})
        |=> $stable(drive_code_q))
        else $error("calibrated code moved while frozen");
endmodule

bind sdcr_regs sdcr_chk #(.NCHAN(NCHAN), .CODE_W(CODE_W)) i_sdcr_chk (.*);

// *** sim/tb.sv ***
// testbench for the drive current register bank
// assumes sdcr_regs with default parameters
`timescale 1ns/1ps
`include "sdcr_consts.vh"

module tb;
    localparam logic [9:0] A_CFG = {`SDCR_IDX_CONFIG, 2'b00};
    localparam logic [9:0] A_RST = {`SDCR_IDX_SOFT_RESET, 2'b00};
    localparam logic [9:0] A_CH0 = {`SDCR_IDX_CHAN0, 2'b00};
    localparam logic [9:0] A_CH1 = {`SDCR_IDX_CHAN1, 2'b00};
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, activating;
    logic drive_use_prog_q, drive_max_q, amp_corr_en_q, soft_reset_q;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, active_chan;
    logic [2:0] hsize;
    logic [3:0] cal_valid;
    logic [19:0] cal_code;
    logic [4:0] drive_code_q;
    int failures, n_tests;
    assign hready = hreadyout;
    sdcr_regs i_sdcr_regs (.*);

    task automatic close_out;
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask

    // bounded, so a stuck slave still ends the run
    task automatic wt;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 99);
        if (hready !== 1'b1) begin
            chk(32'h0000_0000, 32'h0000_0001);
            close_out();
        end
    endtask

    // a read compares against d
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
        {hsel, htrans, hwrite, haddr} <= {3'b110, w, 22'h0, a};
        wt();
        {hsel, htrans, hwdata} <= {3'b000, d};
        wt();
        chk({31'h0, hresp}, 32'h0000_0000);
        if (!w)
            chk(hrdata, d);
    endtask

    task automatic pulse(input logic [4:0] c);
        {cal_valid, cal_code} <= {4'h2, {4{c}}};
        @(posedge hclk);
        cal_valid <= 4'h0;
    endtask

    task automatic t_codes;
        xfer(1'b0, A_RST, 32'h0000_0000);
        xfer(1'b0, 10'h074, 32'h0000_0000);
        for (int k = 0; k < 4; k++)
            xfer(1'b1, A_CH0 + 10'(4 * k), 32'hFFFF_07FF | 32'(16 + k) << 11);
        for (int k = 0; k < 4; k++)
            xfer(1'b0, A_CH0 + 10'(4 * k), 32'(16 + k) << 11);
    endtask

    task automatic t_cal;
        active_chan <= 2'h1;
        pulse(5'h15);
        xfer(1'b0, A_CH1, 32'h0000_8D40);
        chk(32'(drive_code_q), 32'h0000_0015);
        xfer(1'b1, A_CFG, 32'h0000_2C01);
        pulse(5'h0A);
        xfer(1'b0, A_CH1, 32'h0000_8D40);
        chk(32'({amp_corr_en_q, drive_code_q}), 32'h0000_0015);
    endtask

    task automatic t_drive;
        xfer(1'b1, A_CFG, 32'h0000_3801);
        repeat (2) @(posedge hclk);
        chk(32'({drive_use_prog_q, drive_code_q}), 32'h0000_0031);
        xfer(1'b1, A_CFG, 32'h0000_2801);
        activating <= 1'b1;
        repeat (2) @(posedge hclk);
        chk(32'({drive_use_prog_q, drive_max_q}), 32'h0000_0002);
        xfer(1'b1, A_CFG, 32'h0000_2001);
        repeat (2) @(posedge hclk);
        chk(32'({drive_use_prog_q, drive_max_q}), 32'h0000_0001);
        activating <= 1'b0;
    endtask

    task automatic t_soft;
        int n;
        n = 0;
        xfer(1'b1, A_CFG, 32'h0000_3801);
        xfer(1'b1, A_RST, 32'h0000_8000);
        for (int i = 0; i < 10; i++) begin
            @(posedge hclk);
            n += (soft_reset_q === 1'b1);
        end
        chk(32'(n), 32'h0000_0004);
        xfer(1'b0, A_RST, 32'h0000_0000);
        xfer(1'b0, A_CFG, 32'h0000_2801);
        xfer(1'b0, A_CH1, 32'h0000_0000);
    endtask

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    initial begin
        {hresetn, hsel, hwrite, activating, htrans, active_chan} = 8'h00;
        {haddr, hwdata, cal_valid, cal_code} = 88'h0;
        hsize = 3'b010;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, A_CFG, 32'h0000_2801);
        t_codes();
        t_cal();
        t_drive();
        t_soft();
        close_out();
    end
endmodule
